// >>> cei_pkg.sv
package cei_pkg;

	// ------------------------------------------------------------
	// Register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [11:0] CEI_TASK_KS_OFS = 12'h000;
	localparam logic [11:0] CEI_TASK_CR_OFS = 12'h004;
	localparam logic [11:0] CEI_EV_KS_OFS = 12'h100;
	localparam logic [11:0] CEI_EV_CR_OFS = 12'h104;
	localparam logic [11:0] CEI_EV_ERR_OFS = 12'h108;
	localparam logic [11:0] CEI_EVENT_TASK_SHORTCUTS_OFS = 12'h200;
	localparam logic [11:0] CEI_IRQ_SET_OFS = 12'h304;
	localparam logic [11:0] CEI_IRQ_CLR_OFS = 12'h308;
	localparam logic [11:0] CEI_AUTH_OFS = 12'h400;
	localparam logic [11:0] CEI_ENABLE_OFS = 12'h500;

	// ------------------------------------------------------------
	// Field positions and values
	// ------------------------------------------------------------
	localparam int CEI_BIT_KS = 0;
	localparam int CEI_BIT_CR = 1;
	localparam int CEI_BIT_ERR = 2;
	localparam logic [1:0] CEI_ENABLE_ON = 2'h2;
	localparam logic [1:0] CEI_ENABLE_OFF = 2'h0;
	localparam logic [1:0] CEI_ENABLE_RST = 2'h0;
	localparam logic [2:0] CEI_IRQ_RST = 3'h0;
	localparam logic [31:0] CEI_RDATA_RST = 32'h0000_0000;

	// Read access completes one cycle after it is taken
	localparam int CEI_READ_WAIT = 1;

endpackage

// >>> cei_bus_if.sv
`timescale 1ns/1ps
interface cei_bus_if;
	logic wr;
	logic rd;
	logic [11:0] addr;
	logic [31:0] wdata;

	modport master (
		output wr,
		output rd,
		output addr,
		output wdata
	);
	modport slave (
		input wr,
		input rd,
		input addr,
		input wdata
	);
endinterface

// >>> cei_core.sv
`timescale 1ns/1ps
// Event flags, shortcut, enable state and task pulses
module cei_core
	import cei_pkg::*;
(
	input wire logic mclk,
	input wire logic reset_n,
	cei_bus_if.slave bus,
	input wire logic ks_done_in,
	input wire logic cr_done_in,
	output logic [2:0] flags,
	output logic [2:0] irq_en,
	output logic shortcut,
	output logic [1:0] enable,
	output logic ks_task,
	output logic cr_task
);

	typedef struct packed {
		logic [2:0] flags;
		logic [2:0] irq_en;
		logic shortcut;
		logic [1:0] enable;
		logic ks_task;
		logic cr_task;
	} cei_core_t;

	cei_core_t st_r;
	cei_core_t st_nxt;

	function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
		hit = (a == o);
	endfunction

	always_comb begin
		logic wr_ks;
		logic wr_cr;
		wr_ks = bus.wr && hit(bus.addr, CEI_TASK_KS_OFS) && bus.wdata[0];
		wr_cr = bus.wr && hit(bus.addr, CEI_TASK_CR_OFS) && bus.wdata[0];
		st_nxt = st_r;
		// Task pulses; generation and cipher end by themselves
		st_nxt.ks_task = wr_ks;
		st_nxt.cr_task = wr_cr || (st_r.shortcut && ks_done_in);
		// Software writes flags; hardware set wins over a same-cycle clear
		if (bus.wr && hit(bus.addr, CEI_EV_KS_OFS))
			st_nxt.flags[CEI_BIT_KS] = bus.wdata[0];
		if (bus.wr && hit(bus.addr, CEI_EV_CR_OFS))
			st_nxt.flags[CEI_BIT_CR] = bus.wdata[0];
		if (bus.wr && hit(bus.addr, CEI_EV_ERR_OFS))
			st_nxt.flags[CEI_BIT_ERR] = bus.wdata[0];
		if (ks_done_in)
			st_nxt.flags[CEI_BIT_KS] = 1'b1;
		if (cr_done_in)
			st_nxt.flags[CEI_BIT_CR] = 1'b1;
		if (bus.wr && hit(bus.addr, CEI_EVENT_TASK_SHORTCUTS_OFS))
			st_nxt.shortcut = bus.wdata[0];
		if (bus.wr && hit(bus.addr, CEI_IRQ_SET_OFS))
			st_nxt.irq_en = st_r.irq_en | bus.wdata[2:0];
		if (bus.wr && hit(bus.addr, CEI_IRQ_CLR_OFS))
			st_nxt.irq_en = st_r.irq_en & ~bus.wdata[2:0];
		// Other codes are ignored so the unit only leaves a legal state
		if (bus.wr && hit(bus.addr, CEI_ENABLE_OFS) &&
				(bus.wdata[1:0] == CEI_ENABLE_ON ||
				bus.wdata[1:0] == CEI_ENABLE_OFF))
			st_nxt.enable = bus.wdata[1:0];
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			st_r <= '{flags: 3'h0, irq_en: CEI_IRQ_RST, shortcut: 1'b0,
				enable: CEI_ENABLE_RST, ks_task: 1'b0, cr_task: 1'b0};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign flags = st_r.flags;
	assign irq_en = st_r.irq_en;
	assign shortcut = st_r.shortcut;
	assign enable = st_r.enable;
	assign ks_task = st_r.ks_task;
	assign cr_task = st_r.cr_task;

	chk_short_trigger: assert property (@(posedge mclk) disable iff (!reset_n)
		(st_r.shortcut && ks_done_in) |=> st_r.cr_task)
		else $error("shortcut did not start cipher");
	chk_short_off: assert property (@(posedge mclk) disable iff (!reset_n)
		(!st_r.shortcut && !(bus.wr && bus.addr == CEI_TASK_CR_OFS))
		|=> !st_r.cr_task)
		else $error("cipher started without cause");
	chk_flag_sticky: assert property (@(posedge mclk) disable iff (!reset_n)
		ks_done_in |=> st_r.flags[CEI_BIT_KS])
		else $error("keystream flag not set");
	chk_set_wins: assert property (@(posedge mclk) disable iff (!reset_n)
		(cr_done_in && bus.wr && bus.addr == CEI_EV_CR_OFS)
		|=> st_r.flags[CEI_BIT_CR])
		else $error("clear beat hardware set");

endmodule // cei_core

// >>> cei_regs.sv
// Implementation choice: register access over Avalon-MM.
`timescale 1ns/1ps
// Notes on behaviour
// - Shortcut bit starts cipher on keystream done
// - Set bit0 enables keystream interrupt, reads state
// - Set bit1 enables cipher interrupt, reads state
// - Set bit2 enables error interrupt, reads state
// - Clear bit0 disables keystream interrupt
// - Clear bit1 disables cipher interrupt
// - Clear bit2 disables error interrupt
// - Read-only auth result, resets to zero
// - Enable field: 2 on, 0 off
// - Keystream task starts, ends with done event
// - Cipher task starts, ends with done event
module cei_regs
	import cei_pkg::*;
(
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic [11:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic keystream_done_event,
	input wire logic cipher_start_task_done_event,
	input wire logic auth_pass_in,
	input wire logic auth_valid_in,
	output logic keystream_start_task,
	output logic cipher_start_task,
	output logic block_on,
	output logic irq
);

	// ------------------------------------------------------------
	// Bus side state
	// ------------------------------------------------------------
	typedef struct packed {
		logic wreq;
		logic [31:0] rdata;
		logic auth;
		logic irq;
		logic on;
	} cei_regs_t;

	cei_regs_t st_r;
	cei_regs_t st_nxt;

	logic [2:0] flags;
	logic [2:0] irq_en;
	logic shortcut;
	logic [1:0] enable;
	logic ks_task;
	logic cr_task;
	logic wr_ok;

	cei_bus_if bus ();

	// Writes act only in the acknowledged cycle; lane 0 must be enabled
	assign wr_ok = avs_write && avs_byteenable[0] && !st_r.wreq;
	assign bus.wr = wr_ok;
	assign bus.rd = avs_read;
	assign bus.addr = avs_address;
	assign bus.wdata = avs_writedata;

	cei_core u_core (
		.mclk(mclk),
		.reset_n(reset_n),
		.bus(bus.slave),
		.ks_done_in(keystream_done_event),
		.cr_done_in(cipher_start_task_done_event),
		.flags(flags),
		.irq_en(irq_en),
		.shortcut(shortcut),
		.enable(enable),
		.ks_task(ks_task),
		.cr_task(cr_task)
	);

	function automatic logic [31:0] rd_mux(input logic [11:0] a);
		case (a)
			CEI_EV_KS_OFS: rd_mux = {31'h0, flags[CEI_BIT_KS]};
			CEI_EV_CR_OFS: rd_mux = {31'h0, flags[CEI_BIT_CR]};
			CEI_EV_ERR_OFS: rd_mux = {31'h0, flags[CEI_BIT_ERR]};
			CEI_EVENT_TASK_SHORTCUTS_OFS: rd_mux = {31'h0, shortcut};
			CEI_IRQ_SET_OFS: rd_mux = {29'h0, irq_en};
			CEI_IRQ_CLR_OFS: rd_mux = {29'h0, irq_en};
			CEI_AUTH_OFS: rd_mux = {31'h0, st_r.auth};
			CEI_ENABLE_OFS: rd_mux = {30'h0, enable};
			default: rd_mux = CEI_RDATA_RST;
		endcase
	endfunction

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		// Every access waits one cycle so waitrequest comes from a flop
		st_nxt.wreq = !((avs_read || avs_write) && st_r.wreq);
		if (avs_read && st_r.wreq)
			st_nxt.rdata = rd_mux(avs_address);
		// Result latched by the datapath at the end of decryption
		if (auth_valid_in)
			st_nxt.auth = auth_pass_in;
		st_nxt.irq = |(flags & irq_en);
		st_nxt.on = (enable == CEI_ENABLE_ON);
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			st_r <= '{wreq: 1'b1, rdata: CEI_RDATA_RST, auth: 1'b0,
				irq: 1'b0, on: 1'b0};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign avs_readdata = st_r.rdata;
	assign avs_waitrequest = st_r.wreq;
	assign keystream_start_task = ks_task;
	assign cipher_start_task = cr_task;
	assign block_on = st_r.on;
	assign irq = st_r.irq;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	chk_irq_level: assert property (@(posedge mclk) disable iff (!reset_n)
		(|(flags & irq_en)) |=> irq)
		else $error("irq missing for enabled flag");
	chk_irq_quiet: assert property (@(posedge mclk) disable iff (!reset_n)
		!(|(flags & irq_en)) |=> !irq)
		else $error("irq without enabled flag");
	chk_set_enable: assert property (@(posedge mclk) disable iff (!reset_n)
		(wr_ok && avs_address == CEI_IRQ_SET_OFS && avs_writedata[0])
		|=> irq_en[0])
		else $error("set did not enable");
	chk_clr_disable: assert property (@(posedge mclk) disable iff (!reset_n)
		(wr_ok && avs_address == CEI_IRQ_CLR_OFS && avs_writedata[1])
		|=> !irq_en[1])
		else $error("clear did not disable");
	chk_enable_on: assert property (@(posedge mclk) disable iff (!reset_n)
		(wr_ok && avs_address == CEI_ENABLE_OFS &&
		avs_writedata[1:0] == CEI_ENABLE_ON) |=> ##1 block_on)
		else $error("enable did not switch on");
	chk_ks_task: assert property (@(posedge mclk) disable iff (!reset_n)
		(wr_ok && avs_address == CEI_TASK_KS_OFS && avs_writedata[0])
		|=> keystream_start_task ##1 !keystream_start_task)
		else $error("keystream task not one pulse");
	chk_read_wait: assert property (@(posedge mclk) disable iff (!reset_n)
		(avs_read && avs_waitrequest) |=> (avs_read |-> !avs_waitrequest))
		else $error("read waited too long");
	chk_auth_hold: assert property (@(posedge mclk) disable iff (!reset_n)
		!auth_valid_in |=> $stable(st_r.auth))
		else $error("auth result changed");

endmodule // cei_regs

// >>> tb.sv
`timescale 1ns/1ps
module tb;
	import cei_pkg::*;
	logic mclk = 1'b0;
	logic reset_n = 1'b0;
	logic [11:0] avs_address = 12'h000;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [3:0] avs_byteenable = 4'h0;
	logic keystream_done_event = 1'b0;
	logic cipher_start_task_done_event = 1'b0;
	logic auth_pass_in = 1'b0;
	logic auth_valid_in = 1'b0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic keystream_start_task;
	logic cipher_start_task;
	logic block_on;
	logic irq;
	int n_errors = 0;
	int checks = 0;
	int ks_n = 0;
	int cr_n = 0;
	logic [31:0] q;
	logic [2:0] en;
	logic [2:0] m;
	logic [11:0] regs [7] = '{CEI_EV_KS_OFS, CEI_EV_CR_OFS, CEI_EV_ERR_OFS,
		CEI_EVENT_TASK_SHORTCUTS_OFS, CEI_IRQ_SET_OFS, CEI_AUTH_OFS, 12'h7fc};

	always #25 mclk = ~mclk;

	cei_regs DUT (
		.mclk(mclk),
		.reset_n(reset_n),
		.avs_address(avs_address),
		.avs_read(avs_read),
		.avs_write(avs_write),
		.avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.keystream_done_event(keystream_done_event),
		.cipher_start_task_done_event(cipher_start_task_done_event),
		.auth_pass_in(auth_pass_in),
		.auth_valid_in(auth_valid_in),
		.keystream_start_task(keystream_start_task),
		.cipher_start_task(cipher_start_task),
		.block_on(block_on),
		.irq(irq)
	);

	// Counting high cycles also catches a pulse that lasts too long
	always @(posedge mclk) begin
		if (keystream_start_task === 1'b1)
			ks_n <= ks_n + 1;
		if (cipher_start_task === 1'b1)
			cr_n <= cr_n + 1;
	end

	// ------------------------------------------------------------
	// Bus and check tasks
	// ------------------------------------------------------------
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// Waitrequest and read data are taken at the rising edge, as sampled
	task bus(input logic r, input logic [11:0] a, input logic [31:0] d,
			input logic [3:0] be);
		int n;
		@(posedge mclk);
		avs_address <= a;
		avs_read <= r;
		avs_write <= ~r;
		avs_writedata <= d;
		avs_byteenable <= be;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		if (avs_waitrequest !== 1'b0) begin
			n_errors++;
			$display("[ERR] %0t bus answer timed out", $time);
		end
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task wr(input logic [11:0] a, input logic [31:0] d);
		bus(1'b0, a, d, 4'hf);
	endtask

	task rdc(input logic [11:0] a, input logic [31:0] e);
		bus(1'b1, a, 32'h0000_0000, 4'hf);
		chk(q, e);
	endtask

	task pulse(input int k, input logic p);
		@(posedge mclk);
		auth_pass_in <= p;
		keystream_done_event <= (k == 0);
		cipher_start_task_done_event <= (k == 1);
		auth_valid_in <= (k == 2);
		@(posedge mclk);
		keystream_done_event <= 1'b0;
		cipher_start_task_done_event <= 1'b0;
		auth_valid_in <= 1'b0;
	endtask

	task w8(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	task wrap_up;
		$display("n_errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		repeat (5000) @(posedge mclk);
		n_errors++;
		$display("[ERR] %0t watchdog expired", $time);
		wrap_up();
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		void'($urandom(32'h0c3b_5f9c));
		repeat (8) @(posedge mclk);
		reset_n <= 1'b1;
		foreach (regs[j]) rdc(regs[j], 32'h0000_0000);
		rdc(CEI_ENABLE_OFS, 32'h0000_0000);
		en = 3'h0;
		for (int i = 0; i < 24; i++) begin
			m = 3'($urandom);
			if ($urandom_range(1, 0) == 1) begin
				wr(CEI_IRQ_SET_OFS, {29'($urandom), m});
				en = en | m;
			end else begin
				wr(CEI_IRQ_CLR_OFS, {29'($urandom), m});
				en = en & ~m;
			end
			rdc(CEI_IRQ_SET_OFS, {29'h0, en});
			rdc(CEI_IRQ_CLR_OFS, {29'h0, en});
		end
		wr(CEI_TASK_KS_OFS, 32'h0000_0001);
		wr(CEI_TASK_CR_OFS, 32'h0000_0001);
		w8(2);
		chk(32'(ks_n), 32'h0000_0001);
		chk(32'(cr_n), 32'h0000_0001);
		wr(CEI_IRQ_CLR_OFS, 32'h0000_0007);
		pulse(0, 1'b0);
		pulse(1, 1'b0);
		w8(2);
		chk(32'(cr_n), 32'h0000_0001);
		chk({31'h0, irq}, 32'h0000_0000);
		rdc(CEI_EV_KS_OFS, 32'h0000_0001);
		wr(CEI_IRQ_SET_OFS, 32'h0000_0002);
		w8(2);
		chk({31'h0, irq}, 32'h0000_0001);
		wr(CEI_EV_CR_OFS, 32'h0000_0000);
		w8(2);
		chk({31'h0, irq}, 32'h0000_0000);
		rdc(CEI_EV_CR_OFS, 32'h0000_0000);
		wr(CEI_EVENT_TASK_SHORTCUTS_OFS, 32'h0000_0001);
		rdc(CEI_EVENT_TASK_SHORTCUTS_OFS, 32'h0000_0001);
		// Without lane 0 enabled the write must be ignored
		bus(1'b0, CEI_EVENT_TASK_SHORTCUTS_OFS, 32'h0000_0000, 4'he);
		rdc(CEI_EVENT_TASK_SHORTCUTS_OFS, 32'h0000_0001);
		pulse(0, 1'b0);
		w8(2);
		chk(32'(cr_n), 32'h0000_0002);
		wr(CEI_EV_ERR_OFS, 32'h0000_0001);
		rdc(CEI_EV_ERR_OFS, 32'h0000_0001);
		wr(CEI_EV_ERR_OFS, 32'h0000_0000);
		rdc(CEI_EV_ERR_OFS, 32'h0000_0000);
		wr(CEI_ENABLE_OFS, 32'h0000_0002);
		w8(3);
		chk({31'h0, block_on}, 32'h0000_0001);
		wr(CEI_ENABLE_OFS, 32'h0000_0003);
		rdc(CEI_ENABLE_OFS, 32'h0000_0002);
		wr(CEI_ENABLE_OFS, 32'h0000_0000);
		w8(3);
		chk({31'h0, block_on}, 32'h0000_0000);
		pulse(2, 1'b1);
		rdc(CEI_AUTH_OFS, 32'h0000_0001);
		wr(CEI_AUTH_OFS, 32'h0000_0000);
		rdc(CEI_AUTH_OFS, 32'h0000_0001);
		pulse(2, 1'b0);
		rdc(CEI_AUTH_OFS, 32'h0000_0000);
		pulse(2, 1'b1);
		wr(CEI_ENABLE_OFS, 32'h0000_0002);
		wr(CEI_IRQ_SET_OFS, 32'h0000_0007);
		// Mid-run reset must bring auth, enable, interrupt enables and block_on back to their reset values
		@(posedge mclk);
		reset_n <= 1'b0;
		repeat (2) @(posedge mclk);
		reset_n <= 1'b1;
		rdc(CEI_AUTH_OFS, 32'h0000_0000);
		rdc(CEI_ENABLE_OFS, 32'h0000_0000);
		rdc(CEI_IRQ_SET_OFS, 32'h0000_0000);
		chk({31'h0, block_on}, 32'h0000_0000);
		wrap_up();
	end
endmodule // tb
